// [hw/sptc_defines.vh]
// constants of the step pulse time calculator
`ifndef SPTC_DEFINES_VH
`define SPTC_DEFINES_VH

// timing
`define SPTC_CLK_NS 32'h00000064
`define SPTC_CYCLE_NS 32'h00000fa0
// 2^32 / 4000, rounded up so the quotient never falls short
`define SPTC_RECIP_CYCLE 32'h0010624e
`define SPTC_RAMP_SEGS 6'h20
`define SPTC_SEG_MAX 5'h1f
`define SPTC_FIRST_OFF_NS 12'h001

// steps per shaft revolution
`define SPTC_STEPS_FULL 32'h000000c8
`define SPTC_STEPS_FINE 32'h0000c800

// multiplier configuration register values
`define SPTC_MCFG_MUL 1'b0
`define SPTC_MCFG_MAC 1'b1

// network startup states
`define SPTC_NET_DISC 2'h0
`define SPTC_NET_PARAM 2'h1
`define SPTC_NET_SYNC 2'h2
`define SPTC_NET_IO 2'h3

// motion profile phases
`define SPTC_PH_IDLE 2'h0
`define SPTC_PH_RAMP 2'h1
`define SPTC_PH_CONST 2'h2
`define SPTC_PH_DECL 2'h3

`endif

// [hw/sptc_ramp_rom.v]
// ramp coefficient table: 1000 / sin^2 per segment, shared by both ramps
module sptc_ramp_rom (
    // lookup
    input wire [4:0] i_seg,
    output reg [31:0] o_coef
);
    always @* begin
        case (i_seg)
            5'h00: o_coef = 32'h000654d9;
            5'h01: o_coef = 32'h0001969b;
            5'h02: o_coef = 32'h0000b56f;
            5'h03: o_coef = 32'h000066a2;
            5'h04: o_coef = 32'h0000422a;
            5'h05: o_coef = 32'h00002e5b;
            5'h06: o_coef = 32'h0000226b;
            5'h07: o_coef = 32'h00001aac;
            5'h08: o_coef = 32'h0000155e;
            5'h09: o_coef = 32'h00001194;
            5'h0a: o_coef = 32'h00000ec8;
            5'h0b: o_coef = 32'h00000ca8;
            5'h0c: o_coef = 32'h00000b02;
            5'h0d: o_coef = 32'h000009b5;
            5'h0e: o_coef = 32'h000008a9;
            5'h0f: o_coef = 32'h000007d0;
            5'h10: o_coef = 32'h0000071d;
            5'h11: o_coef = 32'h0000068a;
            5'h12: o_coef = 32'h0000060e;
            5'h13: o_coef = 32'h000005a6;
            5'h14: o_coef = 32'h0000054f;
            5'h15: o_coef = 32'h00000506;
            5'h16: o_coef = 32'h000004c8;
            5'h17: o_coef = 32'h00000494;
            5'h18: o_coef = 32'h00000468;
            5'h19: o_coef = 32'h00000444;
            5'h1a: o_coef = 32'h00000427;
            5'h1b: o_coef = 32'h00000410;
            5'h1c: o_coef = 32'h000003fe;
            5'h1d: o_coef = 32'h000003f2;
            5'h1e: o_coef = 32'h000003ea;
            default: o_coef = 32'h000003e8;
        endcase
    end
endmodule

// [hw/sptc_mult.v]
// 32x32 multiplier with config, operand and 64-bit product registers
`include "sptc_defines.vh"
module sptc_mult (
    // clock and reset
    input wire i_mclk,
    input wire i_rst,
    // register writes
    input wire i_cfg_we,
    input wire i_cfg,
    input wire i_op_we,
    input wire [31:0] i_operand_a,
    input wire [31:0] i_operand_b,
    // transfer-in with id zero
    input wire i_xfer,
    // results
    output wire [31:0] o_product_low,
    output wire [31:0] o_product_high
);
    reg multiplier_config_reg;
    reg [31:0] operand_a_reg;
    reg [31:0] operand_b_reg;
    reg [31:0] product_low_reg;
    reg [31:0] product_high_reg;
    wire [63:0] prod;
    wire [63:0] acc;

    assign prod = {32'h00000000, operand_a_reg} * {32'h00000000, operand_b_reg};
    assign acc = {product_high_reg, product_low_reg} + prod;
    assign o_product_low = product_low_reg;
    assign o_product_high = product_high_reg;

    always @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            multiplier_config_reg <= `SPTC_MCFG_MUL;
            operand_a_reg <= 32'h00000000;
            operand_b_reg <= 32'h00000000;
            product_low_reg <= 32'h00000000;
            product_high_reg <= 32'h00000000;
        end else begin
            if (i_cfg_we) begin
                multiplier_config_reg <= i_cfg;
            end
            if (i_op_we) begin
                operand_a_reg <= i_operand_a;
                operand_b_reg <= i_operand_b;
            end
            if (i_xfer) begin
                if (multiplier_config_reg == `SPTC_MCFG_MAC) begin
                    product_low_reg <= acc[31:0];
                    product_high_reg <= acc[63:32];
                end else begin
                    product_low_reg <= prod[31:0];
                    product_high_reg <= prod[63:32];
                end
            end
        end
    end
endmodule

// [hw/sptc_step_time_calc.v]
// step pulse time planner for four axes on a 4 us network cycle
// Summary of operation
// - run motion loop once per 250 kHz cycle
// - profile ramps up, cruises, ramps down
// - step interval never below one 4 us cycle
// - ramp has 32 sine-squared segments
// - one table for accelerating and decelerating
// - interval is table entry times frequency constant
// - split interval into cycles and residual
// - add previous offset, carry into cycle count
// - yield wait count and next offset
// - table holds 1000 over sine-squared
// - frequency constant gives ns shifted 16
// - divide by 4000 via reciprocal high word
// - full 64-bit product kept
// - five multiplier registers, first selects mode
// - transfer-in completes multiply in one cycle
// - product split into low and high registers
// - one frame per cycle to four units, skipped if a start is accepted on the tick
// - cyclic exchange only after startup sequence
// - emit step offsets, direction, driver commands
// - 200 or 51200 steps per revolution
// - zero offset when no pulse this cycle
`include "sptc_defines.vh"
module sptc_step_time_calc (
    // clock and reset
    input wire i_mclk,
    input wire i_rst,
    // motion command
    input wire i_start,
    input wire [3:0] i_axis_sel,
    input wire [3:0] i_dir,
    input wire [15:0] i_revs,
    input wire i_fine_step,
    input wire [31:0] i_freq_recip,
    // network state
    input wire [1:0] i_net_state,
    // frame contents
    output reg o_frame_valid,
    output reg [47:0] o_pulse_off,
    output reg [3:0] o_dir,
    output reg [3:0] o_drv_en,
    // status
    output reg o_busy,
    output reg [1:0] o_phase,
    output reg o_cyclic
);
    localparam [31:0] CYC_RATIO = `SPTC_CYCLE_NS / `SPTC_CLK_NS;
    localparam [5:0] CYC_CLKS = CYC_RATIO[5:0];
    localparam [31:0] CYC_NS = `SPTC_CYCLE_NS;
    localparam [2:0] E_IDLE = 3'h0;
    localparam [2:0] E_L1 = 3'h1;
    localparam [2:0] E_X1 = 3'h2;
    localparam [2:0] E_L2 = 3'h3;
    localparam [2:0] E_X2 = 3'h4;
    localparam [2:0] E_L3 = 3'h5;
    localparam [2:0] E_X3 = 3'h6;
    localparam [2:0] E_FIX = 3'h7;

    // 32 ramp segments
    // ramp segment: rises with steps done, falls with steps left
    function [4:0] seg_of;
        input [31:0] done;
        input [31:0] left;
        reg [31:0] m;
        begin
            m = (done < left - 32'h00000001) ? done : left - 32'h00000001;
            seg_of = (m > {27'h0000000, `SPTC_SEG_MAX}) ? `SPTC_SEG_MAX : m[4:0];
        end
    endfunction

    reg [5:0] tick_cnt_q;
    reg [1:0] stage_q;
    reg [2:0] est_q;
    reg [1:0] ax_q;
    reg [3:0] act_q;
    reg [3:0] req_q;
    reg [31:0] wait_cycle_count_q [0:3];
    reg [11:0] off_q [0:3];
    reg [31:0] done_q [0:3];
    reg [31:0] left_q [0:3];
    reg [31:0] tstep_q;
    reg [31:0] cnt_q;
    reg [31:0] freq_q;
    reg [31:0] op_a;
    reg [31:0] op_b;
    reg [1:0] lead;
    reg [4:0] lead_seg;
    wire tick;
    wire start_ok;
    wire [31:0] total;
    wire [31:0] coef;
    wire [31:0] p_lo;
    wire [31:0] p_hi;
    wire [31:0] t_ns;
    wire [33:0] diff;
    wire [33:0] cyc34;
    integer i;
    integer j;

    assign tick = (tick_cnt_q == CYC_CLKS - 6'h01);
    assign start_ok = i_start && !o_busy && o_cyclic;
    assign total = i_fine_step ? ({16'h0000, i_revs} * `SPTC_STEPS_FINE)
                               : ({16'h0000, i_revs} * `SPTC_STEPS_FULL);
    // ns value sits 16 bits up in the product
    assign t_ns = {p_hi[15:0], p_lo[31:16]};
    assign cyc34 = {2'b00, `SPTC_CYCLE_NS};
    // previous offset plus new interval minus whole cycles
    assign diff = {22'h000000, off_q[ax_q]} + {2'b00, tstep_q} - {2'b00, p_lo};

    sptc_ramp_rom u_rom (
        .i_seg(seg_of(done_q[ax_q], left_q[ax_q])),
        .o_coef(coef)
    );

    sptc_mult u_mult (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_cfg_we(start_ok),
        .i_cfg(`SPTC_MCFG_MUL),
        .i_op_we((est_q == E_L1) || (est_q == E_L2) || (est_q == E_L3)),
        .i_operand_a(op_a),
        .i_operand_b(op_b),
        .i_xfer((est_q == E_X1) || (est_q == E_X2) || (est_q == E_X3)),
        .o_product_low(p_lo),
        .o_product_high(p_hi)
    );

    // operand selection per engine step
    always @* begin
        op_a = 32'h00000000;
        op_b = 32'h00000000;
        case (est_q)
            E_L1: begin
                op_a = coef;
                op_b = freq_q;
            end
            // reciprocal of 4000, high word is quotient
            E_L2: begin
                op_a = (t_ns < `SPTC_CYCLE_NS) ? `SPTC_CYCLE_NS : t_ns;
                op_b = `SPTC_RECIP_CYCLE;
            end
            E_L3: begin
                op_a = `SPTC_CYCLE_NS;
                op_b = p_hi;
            end
            default: begin
                op_a = 32'h00000000;
                op_b = 32'h00000000;
            end
        endcase
    end

    // lowest active axis stands for the shared profile
    always @* begin
        lead = 2'h0;
        for (j = 3; j >= 0; j = j - 1) begin
            if (act_q[j]) begin
                lead = j[1:0];
            end
        end
        lead_seg = seg_of(done_q[lead], left_q[lead]);
    end

    // network startup and cycle timer
    always @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            tick_cnt_q <= 6'h00;
            stage_q <= `SPTC_NET_DISC;
            o_cyclic <= 1'b0;
        end else begin
            // one loop pass per 4 us
            tick_cnt_q <= tick ? 6'h00 : tick_cnt_q + 6'h01;
            if (i_net_state == `SPTC_NET_DISC) begin
                stage_q <= `SPTC_NET_DISC;
                o_cyclic <= 1'b0;
            end else if (i_net_state == stage_q + 2'h1) begin
                stage_q <= i_net_state;
                o_cyclic <= (i_net_state == `SPTC_NET_IO);
            end else if (i_net_state != stage_q) begin
                o_cyclic <= 1'b0;
            end
        end
    end

    // per-axis motion state, frame build and calculation engine
    always @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            est_q <= E_IDLE;
            ax_q <= 2'h0;
            act_q <= 4'h0;
            req_q <= 4'h0;
            tstep_q <= 32'h00000000;
            cnt_q <= 32'h00000000;
            freq_q <= 32'h00000000;
            o_frame_valid <= 1'b0;
            o_pulse_off <= 48'h000000000000;
            o_dir <= 4'h0;
            o_drv_en <= 4'h0;
            o_busy <= 1'b0;
            o_phase <= `SPTC_PH_IDLE;
            for (i = 0; i < 4; i = i + 1) begin
                wait_cycle_count_q[i] <= 32'h00000000;
                off_q[i] <= 12'h000;
                done_q[i] <= 32'h00000000;
                left_q[i] <= 32'h00000000;
            end
        end else begin
            o_frame_valid <= 1'b0;
            o_busy <= (act_q != 4'h0) || (req_q != 4'h0);
            if (act_q == 4'h0) begin
                o_phase <= `SPTC_PH_IDLE;
            end else if (lead_seg == `SPTC_SEG_MAX) begin
                o_phase <= `SPTC_PH_CONST;
            end else if (done_q[lead] < left_q[lead] - 32'h00000001) begin
                o_phase <= `SPTC_PH_RAMP;
            end else begin
                o_phase <= `SPTC_PH_DECL;
            end
            // motor units must already hold their microstep setting
            if (start_ok) begin
                freq_q <= i_freq_recip;
                o_dir <= i_dir;
                o_drv_en <= i_axis_sel;
                for (i = 0; i < 4; i = i + 1) begin
                    if (i_axis_sel[i] && total != 32'h00000000) begin
                        act_q[i] <= 1'b1;
                        wait_cycle_count_q[i] <= 32'h00000000;
                        off_q[i] <= `SPTC_FIRST_OFF_NS;
                        done_q[i] <= 32'h00000000;
                        left_q[i] <= total;
                    end
                end
            end else if (tick && o_cyclic) begin
                // one frame for all four units each cycle, none if a start is accepted on the tick
                o_frame_valid <= 1'b1;
                for (i = 0; i < 4; i = i + 1) begin
                    // zero means no pulse this cycle
                    o_pulse_off[i*12 +: 12] <= 12'h000;
                    if (act_q[i] && wait_cycle_count_q[i] == 32'h00000000) begin
                        o_pulse_off[i*12 +: 12] <= off_q[i];
                        done_q[i] <= done_q[i] + 32'h00000001;
                        left_q[i] <= left_q[i] - 32'h00000001;
                        if (left_q[i] == 32'h00000001) begin
                            // clear carry on return to idle
                            act_q[i] <= 1'b0;
                            off_q[i] <= 12'h000;
                            o_drv_en[i] <= 1'b0;
                        end else begin
                            req_q[i] <= 1'b1;
                        end
                    end else if (act_q[i]) begin
                        wait_cycle_count_q[i] <= wait_cycle_count_q[i] - 32'h00000001;
                    end
                end
            end
            // scan axes, eight clocks each, within 40
            case (est_q)
                E_IDLE: begin
                    if (req_q[ax_q]) begin
                        est_q <= E_L1;
                    end else begin
                        ax_q <= ax_q + 2'h1;
                    end
                end
                E_L1: est_q <= E_X1;
                E_X1: est_q <= E_L2;
                E_L2: begin
                    // interval held to at least one cycle
                    tstep_q <= op_a;
                    est_q <= E_X2;
                end
                E_X2: est_q <= E_L3;
                E_L3: begin
                    cnt_q <= p_hi;
                    est_q <= E_X3;
                end
                E_X3: est_q <= E_FIX;
                default: begin
                    // quotient rounded up may overshoot by one
                    if (diff[33]) begin
                        wait_cycle_count_q[ax_q] <= cnt_q - 32'h00000002;
                        off_q[ax_q] <= diff[11:0] + CYC_NS[11:0];
                    end else if (diff > cyc34) begin
                        // residual past a cycle bumps the count
                        // exactly 4000 stays below as offset 4000, never a lost zero
                        wait_cycle_count_q[ax_q] <= cnt_q;
                        off_q[ax_q] <= diff[11:0] - CYC_NS[11:0];
                    end else if (diff == 34'h000000000) begin
                        // boundary pulse kept nonzero, zero means none
                        wait_cycle_count_q[ax_q] <= cnt_q - 32'h00000002;
                        off_q[ax_q] <= CYC_NS[11:0];
                    end else begin
                        wait_cycle_count_q[ax_q] <= cnt_q - 32'h00000001;
                        off_q[ax_q] <= diff[11:0];
                    end
                    req_q[ax_q] <= 1'b0;
                    ax_q <= ax_q + 2'h1;
                    est_q <= E_IDLE;
                end
            endcase
        end
    end
endmodule

// [dv/sptc_step_time_calc_sva.sv]
// port assertions for the step pulse time calculator
module sptc_step_time_calc_sva (
    // clock and reset
    input wire i_mclk,
    input wire i_rst,
    // inputs watched
    input wire i_start,
    input wire [3:0] i_axis_sel,
    input wire [3:0] i_dir,
    input wire [15:0] i_revs,
    input wire [1:0] i_net_state,
    // outputs watched
    input wire o_frame_valid,
    input wire [47:0] o_pulse_off,
    input wire [3:0] o_dir,
    input wire [3:0] o_drv_en,
    input wire o_busy,
    input wire [1:0] o_phase,
    input wire o_cyclic
);
    // 32 bits so a long pause before cyclic cannot wrap the count
    logic [31:0] gap_q;
    logic seen_q;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    always @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            gap_q <= 32'h0;
            seen_q <= 1'b0;
        end else if (o_frame_valid) begin
            gap_q <= 32'h0;
            seen_q <= 1'b1;
        end else begin
            gap_q <= gap_q + 32'h1;
        end
    end
    // skipped frames still land on the 40-clock grid
    property p_frame_period;
        o_frame_valid && seen_q |-> (gap_q % 40) == 39;
    endproperty
    a_frame_period: assert property (p_frame_period)
        else $error("frame spacing off the cycle grid");
    property p_frame_cyclic;
        o_frame_valid |-> $past(o_cyclic);
    endproperty
    a_frame_cyclic: assert property (p_frame_cyclic)
        else $error("frame without cyclic exchange");
    property p_off_range;
        o_frame_valid |-> o_pulse_off[11:0] <= 12'hfa0 && o_pulse_off[23:12] <= 12'hfa0
            && o_pulse_off[35:24] <= 12'hfa0 && o_pulse_off[47:36] <= 12'hfa0;
    endproperty
    a_off_range: assert property (p_off_range)
        else $error("pulse offset beyond one cycle");
    property p_cyc_order;
        $rose(o_cyclic) |-> $past(i_net_state) == 2'h3 && $past(i_net_state, 2) == 2'h2;
    endproperty
    a_cyc_order: assert property (p_cyc_order)
        else $error("cyclic entered out of order");
    property p_cyc_drop;
        o_cyclic && i_net_state != 2'h3 |=> !o_cyclic;
    endproperty
    a_cyc_drop: assert property (p_cyc_drop)
        else $error("cyclic kept after state change");
    property p_accept;
        i_start && !o_busy && o_cyclic && i_axis_sel != 4'h0 && i_revs != 16'h0
            |=> o_drv_en == $past(i_axis_sel) && o_dir == $past(i_dir) ##1 o_busy;
    endproperty
    a_accept: assert property (p_accept)
        else $error("start not taken as commanded");
    property p_idle_zero;
        o_frame_valid && !o_busy |-> o_pulse_off == 48'h0;
    endproperty
    a_idle_zero: assert property (p_idle_zero)
        else $error("pulse offset sent while idle");
    property p_phase_seq;
        o_phase != $past(o_phase) |-> o_phase == $past(o_phase) + 2'h1;
    endproperty
    a_phase_seq: assert property (p_phase_seq)
        else $error("profile phase out of order");
    property p_end_clear;
        $fell(o_busy) |-> o_drv_en == 4'h0 && o_phase == 2'h0;
    endproperty
    a_end_clear: assert property (p_end_clear)
        else $error("axis state left after motion");
endmodule
bind sptc_step_time_calc sptc_step_time_calc_sva sptc_step_time_calc_sva_inst (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_start(i_start), .i_axis_sel(i_axis_sel),
    .i_dir(i_dir), .i_revs(i_revs), .i_net_state(i_net_state),
    .o_frame_valid(o_frame_valid), .o_pulse_off(o_pulse_off), .o_dir(o_dir),
    .o_drv_en(o_drv_en), .o_busy(o_busy), .o_phase(o_phase), .o_cyclic(o_cyclic)
);

// [dv/sptc_motor_units.sv]
// model of the four motor units and the network startup walk
module sptc_motor_units (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // network and frame
    input wire logic i_walk,
    input wire logic i_frame_valid,
    input wire logic [47:0] i_pulse_off,
    output logic [1:0] o_net_state,
    output logic o_fine_step,
    // step capture
    output int o_steps [4],
    output int o_first_gap,
    output int o_min_gap
);
    timeunit 1ns;
    timeprecision 1ns;
    int since;
    // full step, fixed before any motion
    assign o_fine_step = 1'b0;
    always @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_net_state <= 2'h0;
            o_steps <= '{0, 0, 0, 0};
            o_first_gap <= 0;
            o_min_gap <= 1000000;
            since <= 0;
        end else begin
            if (!i_walk) o_net_state <= 2'h0;
            else if (o_net_state != 2'h3) o_net_state <= o_net_state + 2'h1;
            if (i_frame_valid) begin
                since <= since + 1;
                // each unit takes its own slice, zero is no pulse
                for (int n = 0; n < 4; n++) begin
                    if (i_pulse_off[12*n +: 12] != 12'h000) o_steps[n] <= o_steps[n] + 1;
                end
                if (i_pulse_off[11:0] != 12'h000) begin
                    since <= 1;
                    if (o_steps[0] == 1) o_first_gap <= since;
                    if (o_steps[0] > 0 && since < o_min_gap) o_min_gap <= since;
                end
            end
        end
    end
endmodule

// [dv/sptc_step_time_calc_bench.sv]
// testbench for the step pulse time calculator
module sptc_step_time_calc_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_mclk, i_rst, i_start, i_fine_step, i_walk, o_frame_valid, o_busy, o_cyclic;
    logic [3:0] i_axis_sel, i_dir, o_dir, o_drv_en;
    logic [15:0] i_revs;
    logic [31:0] i_freq_recip;
    logic [1:0] i_net_state, o_phase;
    logic [47:0] o_pulse_off;
    int steps [4];
    int first_gap, min_gap, miscompares, comparisons, cycles;

    sptc_step_time_calc sptc_step_time_calc_inst (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_start(i_start), .i_axis_sel(i_axis_sel),
        .i_dir(i_dir), .i_revs(i_revs), .i_fine_step(i_fine_step),
        .i_freq_recip(i_freq_recip), .i_net_state(i_net_state),
        .o_frame_valid(o_frame_valid), .o_pulse_off(o_pulse_off), .o_dir(o_dir),
        .o_drv_en(o_drv_en), .o_busy(o_busy), .o_phase(o_phase), .o_cyclic(o_cyclic)
    );
    sptc_motor_units sptc_motor_units_inst (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_walk(i_walk), .i_frame_valid(o_frame_valid),
        .i_pulse_off(o_pulse_off), .o_net_state(i_net_state), .o_fine_step(i_fine_step),
        .o_steps(steps), .o_first_gap(first_gap), .o_min_gap(min_gap)
    );

    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic pulse_start(input logic [3:0] sel, input logic [3:0] dir);
        @(posedge i_mclk);
        i_axis_sel <= sel;
        i_dir <= dir;
        i_start <= 1'b1;
        @(posedge i_mclk);
        i_start <= 1'b0;
        @(posedge i_mclk);
        #1;
    endtask

    task automatic wait_cyclic;
        for (int n = 0; n < 8 && o_cyclic !== 1'b1; n++) begin
            @(posedge i_mclk);
            #1;
        end
    endtask

    // start refused before the walk, cyclic lost and regained
    task automatic sc_startup;
        pulse_start(4'h1, 4'h1);
        repeat (3) @(posedge i_mclk);
        #1;
        check(o_busy, 1'b0);
        check(o_drv_en, 4'h0);
        @(posedge i_mclk);
        i_walk <= 1'b1;
        wait_cyclic();
        check(o_cyclic, 1'b1);
        @(posedge i_mclk);
        i_walk <= 1'b0;
        repeat (2) @(posedge i_mclk);
        #1;
        check(o_cyclic, 1'b0);
        @(posedge i_mclk);
        i_walk <= 1'b1;
        wait_cyclic();
        check(o_cyclic, 1'b1);
    endtask

    // one revolution on axes 0 and 2, full speed at the 4 us limit
    task automatic sc_move;
        int n;
        pulse_start(4'h5, 4'ha);
        check(o_drv_en, 4'h5);
        check(o_dir, 4'ha);
        n = 0;
        while (o_frame_valid !== 1'b1 && n < 100) begin
            @(posedge i_mclk);
            #1;
            n++;
        end
        check(o_pulse_off, 48'h000001000001);
        check(o_phase, 2'h1);
        // a second start while moving must be ignored
        pulse_start(4'hf, 4'h0);
        check(o_drv_en, 4'h5);
        check(o_dir, 4'ha);
        check(o_busy, 1'b1);
        n = 0;
        while (o_busy !== 1'b0 && n < 90000) begin
            @(posedge i_mclk);
            #1;
            n++;
        end
        check(n < 90000, 1'b1);
        check(o_drv_en, 4'h0);
        check(o_phase, 2'h0);
        check(steps[0], 200);
        check(steps[1], 0);
        check(steps[2], 200);
        check(steps[3], 0);
        check(min_gap, 1);
        check(first_gap > 1, 1'b1);
    endtask

    // hang guard, the move needs about 43500 clocks
    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        if (cycles == 95000) begin
            miscompares++;
            close_out();
        end
    end

    initial begin
        i_rst = 1'b1;
        i_start = 1'b0;
        i_walk = 1'b0;
        i_axis_sel = 4'h0;
        i_dir = 4'h0;
        i_revs = 16'h0001;
        i_freq_recip = 32'h00040000;
        miscompares = 0;
        comparisons = 0;
        cycles = 0;
        repeat (8) @(posedge i_mclk);
        i_rst <= 1'b0;
        sc_startup();
        sc_move();
        close_out();
    end
endmodule
